// ===== smsp_core.sv
// serial master/slave port: registers, shift engine and pin control.
// assumes cpu-side strobes and serial pins are synchronous to clk_in.
//
// What this block does
// - interrupt when enabled and done/overrun/fault set
// - port enable resets low, gates pins
// - select low as master drops enable, master
// - rate code picks cpu/4 to cpu/128
// - rate bits ignored in slave mode
// - master drives clock, swaps data pins
// - polarity sets clock idle level
// - phase picks first or second capture edge
// - done flag: status then data access clears
// - data writes ignored while done set, until status read
// - collision flag on busy write, no interrupt
// - overrun on done while flag set
// - fault flag: control access then write clears
// - output disable stops data output drive
// - software select replaces select pin
// - internal select low means selected
// - data write loads shifter, master starts
// - finished byte copied to read buffer unless overrun
// - colliding write leaves transfer untouched
// - fault blocks setting enable and master
`include "smsp_params.svh"

module smsp_core (
   input  wire logic                    clk_in,       // cpu clock, 100 MHz
   input  wire logic                    rst_in,       // sync reset, active high
   input  wire logic [`SMSP_ADDR_W-1:0] addr_in,      // register address
   input  wire logic [7:0]              wdata_in,     // write data
   input  wire logic                    wr_in,        // write strobe
   input  wire logic                    rd_in,        // read strobe
   output logic      [7:0]              rdata_out,    // read data, cycle after rd
   output logic                         irq_out,      // port interrupt, high
   input  wire logic                    sck_in,       // serial clock pin level
   output logic                         sck_out,      // serial clock drive value
   output logic                         sck_oe_n_out, // low while driving clock
   input  wire logic                    mosi_in,      // master-out pin level
   output logic                         mosi_out,     // master-out drive value
   output logic                         mosi_oe_n_out,// low while driving mosi
   input  wire logic                    miso_in,      // master-in pin level
   output logic                         miso_out,     // master-in drive value
   output logic                         miso_oe_n_out,// low while driving miso
   input  wire logic                    ss_n_in       // slave select pin, low
);

   // control fields
   logic       irq_en_q;
   logic       port_enable_q;
   logic       divider_enable_q;
   logic       master_select_q;
   logic       clock_polarity_q;
   logic       clock_phase_q;
   logic [1:0] rate_select_q;
   // status fields
   logic       transfer_done_flag_q;
   logic       write_collision_flag_q;
   logic       overrun_flag_q;
   logic       mode_fault_flag_q;
   logic       output_disable_q;
   logic       select_management_q;
   logic       internal_select_q;
   // clearing-sequence arms
   logic       status_seen_q;
   logic       ctrl_seen_q;
   // shift engine
   logic [7:0] shreg_q;
   logic [7:0] rxbuf_q;
   logic [2:0] bit_cnt_q;
   logic       have_bit_q;
   logic       rx_bit_q;
   logic       sck_prev_q;
   logic       sck_q;
   logic [3:0] toggle_q;
   logic [7:0] rdata_q;
   smsp_pkg::smsp_mst_state_t state_q;

   // decoded accesses
   logic wr_data, wr_ctrl, wr_stat;
   logic rd_data, rd_ctrl, rd_stat;
   logic data_access, done_clr;
   // engine terms
   logic ss_int, slave_act, m_run, m_tick;
   logic s_lead, s_trail, m_lead, m_trail;
   logic lead, trail, cap_edge, sft_edge;
   logic din, last_cap, busy, engine_clr;
   logic data_wr_ok, write_collision_flag_set, mode_fault_flag_evt, buf_free;
   logic [7:0] final_byte;

   // a literal cannot be bit-selected, so the reset pattern is named first
   localparam logic [7:0] stat_rst = `SMSP_STAT_RST;

   // address match, used by every strobe decode
   function automatic logic hit(input logic [`SMSP_ADDR_W-1:0] a,
                                input logic [`SMSP_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // strobe decode
   assign wr_data = wr_in && hit(addr_in, `SMSP_OFS_DATA);
   assign wr_ctrl = wr_in && hit(addr_in, `SMSP_OFS_CTRL);
   assign wr_stat = wr_in && hit(addr_in, `SMSP_OFS_STAT);
   assign rd_data = rd_in && hit(addr_in, `SMSP_OFS_DATA);
   assign rd_ctrl = rd_in && hit(addr_in, `SMSP_OFS_CTRL);
   assign rd_stat = rd_in && hit(addr_in, `SMSP_OFS_STAT);
   assign data_access = rd_data || wr_data;

   assign ss_int = select_management_q ? internal_select_q : ss_n_in;

   // slave takes part only while enabled and selected
   assign slave_act = port_enable_q && !master_select_q && !ss_int;

   assign mode_fault_flag_evt = port_enable_q && master_select_q && !ss_int;

   // slave edges judged against idle level
   assign s_lead  = slave_act && (sck_prev_q == clock_polarity_q)
                    && (sck_in != clock_polarity_q);
   assign s_trail = slave_act && (sck_prev_q != clock_polarity_q)
                    && (sck_in == clock_polarity_q);

   // master edges come from its own divided clock
   assign m_run   = (state_q == smsp_pkg::SMSP_RUN);
   assign m_lead  = m_tick && (sck_q == clock_polarity_q);
   assign m_trail = m_tick && (sck_q != clock_polarity_q);
   assign lead    = s_lead || m_lead;
   assign trail   = s_trail || m_trail;

   assign cap_edge = clock_phase_q ? trail : lead;
   assign sft_edge = clock_phase_q ? lead : trail;

   assign din = master_select_q ? miso_in : mosi_in;

   assign last_cap   = cap_edge && (bit_cnt_q == `SMSP_LAST_BIT);
   assign final_byte = {shreg_q[6:0], din};

   // slave busy from first capture; master busy for its whole clock train
   assign busy = master_select_q ? m_run : ((bit_cnt_q != 3'h0) || have_bit_q);
   assign engine_clr = !port_enable_q || (!master_select_q && ss_int);

   assign done_clr = status_seen_q && data_access;

   assign data_wr_ok = wr_data && (!transfer_done_flag_q || status_seen_q) && !busy;

   assign write_collision_flag_set = wr_data && busy;

   // buffer only refills when the done flag is free or being cleared
   assign buf_free = !transfer_done_flag_q || done_clr;

   smsp_clkdiv u_clkdiv (
      .clk_in            (clk_in),
      .rst_in            (rst_in),
      .run_in            (m_run),
      .divider_enable_in (divider_enable_q),
      .rate_select_in    (rate_select_q),
      .tick_out          (m_tick)
   );

   // control register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         {irq_en_q, port_enable_q, divider_enable_q, master_select_q,
          clock_polarity_q, clock_phase_q, rate_select_q} <= `SMSP_CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            irq_en_q         <= wdata_in[`SMSP_CR_IRQ_EN];
            divider_enable_q <= wdata_in[`SMSP_CR_DIV_EN];
            clock_polarity_q <= wdata_in[`SMSP_CR_CLOCK_POLARITY];
            clock_phase_q    <= wdata_in[`SMSP_CR_CLOCK_PHASE];
            rate_select_q    <= wdata_in[`SMSP_CR_RATE_HI:`SMSP_CR_RATE_LO];
            port_enable_q    <= wdata_in[`SMSP_CR_PORT_EN]
                                && (!mode_fault_flag_q || ctrl_seen_q);
            master_select_q  <= wdata_in[`SMSP_CR_MASTER]
                                && (!mode_fault_flag_q || ctrl_seen_q);
         end
         if (mode_fault_flag_evt) begin
            port_enable_q   <= 1'b0;
            master_select_q <= 1'b0;
         end
      end
   end

   // software-owned bits of the control/status register; bit 3 is not stored
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         output_disable_q    <= stat_rst[`SMSP_SR_OUT_DIS];
         select_management_q <= stat_rst[`SMSP_SR_SEL_MGMT];
         internal_select_q   <= stat_rst[`SMSP_SR_INT_SEL];
      end else if (wr_stat) begin
         output_disable_q    <= wdata_in[`SMSP_SR_OUT_DIS];
         select_management_q <= wdata_in[`SMSP_SR_SEL_MGMT];
         internal_select_q   <= wdata_in[`SMSP_SR_INT_SEL];
      end
   end

   // clearing-sequence arms
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         status_seen_q <= 1'b0;
         ctrl_seen_q   <= 1'b0;
      end else begin
         if (rd_stat) begin
            status_seen_q <= 1'b1;
         end else if (data_access) begin
            status_seen_q <= 1'b0;
         end
         if (!mode_fault_flag_q) begin
            ctrl_seen_q <= 1'b0;
         end else if (rd_ctrl || wr_ctrl) begin
            ctrl_seen_q <= 1'b1;
         end
      end
   end

   // hardware flags: a set in the same cycle as a clear always wins
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         transfer_done_flag_q   <= stat_rst[`SMSP_SR_DONE];
         write_collision_flag_q <= stat_rst[`SMSP_SR_WRITE_COLLISION_FLAG];
         overrun_flag_q         <= stat_rst[`SMSP_SR_OVR];
         mode_fault_flag_q      <= stat_rst[`SMSP_SR_MODE_FAULT_FLAG];
      end else begin
         if (last_cap) begin
            transfer_done_flag_q <= 1'b1;
         end else if (done_clr) begin
            transfer_done_flag_q <= 1'b0;
         end
         if (write_collision_flag_set) begin
            write_collision_flag_q <= 1'b1;
         end else if (done_clr) begin
            write_collision_flag_q <= 1'b0;
         end
         if (last_cap && !buf_free) begin
            overrun_flag_q <= 1'b1;
         end else if (rd_stat) begin
            overrun_flag_q <= 1'b0;
         end
         if (mode_fault_flag_evt) begin
            mode_fault_flag_q <= 1'b1;
         end else if (wr_ctrl && ctrl_seen_q) begin
            mode_fault_flag_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         shreg_q <= `SMSP_BYTE_RST;
      end else if (data_wr_ok) begin
         shreg_q <= wdata_in;
      end else if (last_cap) begin
         shreg_q <= final_byte;
      end else if (sft_edge && have_bit_q) begin
         shreg_q <= {shreg_q[6:0], rx_bit_q};
      end
   end

   // bit bookkeeping; a deselected slave or disabled port starts afresh
   always_ff @(posedge clk_in) begin
      if (rst_in || engine_clr || data_wr_ok || last_cap) begin
         bit_cnt_q  <= 3'h0;
         have_bit_q <= 1'b0;
         rx_bit_q   <= 1'b0;
      end else if (cap_edge) begin
         bit_cnt_q  <= bit_cnt_q + 3'h1;
         have_bit_q <= 1'b1;
         rx_bit_q   <= din;
      end else if (sft_edge) begin
         have_bit_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rxbuf_q <= `SMSP_BYTE_RST;
      end else if (last_cap && buf_free) begin
         rxbuf_q <= final_byte;
      end
   end

   // slave clock sample, compared with the live pin for edge detection
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_in;
      end
   end

   // master start on write
   // sixteen half periods per byte, clock back at idle level afterwards
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q  <= smsp_pkg::SMSP_IDLE;
         toggle_q <= 4'h0;
      end else begin
         case (state_q)
            smsp_pkg::SMSP_IDLE: begin
               toggle_q <= 4'h0;
               if (data_wr_ok && master_select_q && port_enable_q) begin
                  state_q <= smsp_pkg::SMSP_RUN;
               end
            end
            smsp_pkg::SMSP_RUN: begin
               if (!port_enable_q || !master_select_q) begin
                  state_q <= smsp_pkg::SMSP_IDLE;
               end else if (m_tick) begin
                  toggle_q <= toggle_q + 4'h1;
                  if (toggle_q == `SMSP_LAST_TOGGLE) begin
                     state_q <= smsp_pkg::SMSP_IDLE;
                  end
               end
            end
            default: begin
               state_q <= smsp_pkg::SMSP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sck_q <= 1'b0;
      end else if (!m_run) begin
         sck_q <= clock_polarity_q;
      end else if (m_tick) begin
         sck_q <= ~sck_q;
      end
   end

   // read data stands one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_q <= 8'h00;
      end else if (rd_data) begin
         rdata_q <= rxbuf_q;
      end else if (rd_ctrl) begin
         rdata_q <= {irq_en_q, port_enable_q, divider_enable_q, master_select_q,
                     clock_polarity_q, clock_phase_q, rate_select_q};
      end else if (rd_stat) begin
         rdata_q <= {transfer_done_flag_q, write_collision_flag_q, overrun_flag_q,
                     mode_fault_flag_q, 1'b0, output_disable_q,
                     select_management_q, internal_select_q};
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata_out = rdata_q;

   assign irq_out = irq_en_q
                    && (transfer_done_flag_q || overrun_flag_q || mode_fault_flag_q);

   assign sck_out      = sck_q;
   assign sck_oe_n_out = !(port_enable_q && master_select_q);

   // output disable gates data drive
   // a slave only drives miso while selected, to share the line with others
   assign mosi_out      = shreg_q[7];
   assign mosi_oe_n_out = !(port_enable_q && master_select_q && !output_disable_q);
   assign miso_out      = shreg_q[7];
   assign miso_oe_n_out = !(port_enable_q && !master_select_q && !output_disable_q
                            && !ss_int);

endmodule : smsp_core

// ===== smsp_params.svh
// constants for the serial master/slave port: offsets, field positions,
// reset values and divider counts.
// assumes an 8-bit register port at the printed addresses and a 100 MHz clock.
`ifndef SMSP_PARAMS_SVH
`define SMSP_PARAMS_SVH

// register addresses
`define SMSP_ADDR_W        8
`define SMSP_OFS_DATA      8'h21
`define SMSP_OFS_CTRL      8'h22
`define SMSP_OFS_STAT      8'h23

// control register fields
`define SMSP_CR_IRQ_EN     7
`define SMSP_CR_PORT_EN    6
`define SMSP_CR_DIV_EN     5
`define SMSP_CR_MASTER     4
`define SMSP_CR_CLOCK_POLARITY       3
`define SMSP_CR_CLOCK_PHASE       2
`define SMSP_CR_RATE_HI    1
`define SMSP_CR_RATE_LO    0

// control/status register fields
`define SMSP_SR_DONE       7
`define SMSP_SR_WRITE_COLLISION_FLAG       6
`define SMSP_SR_OVR        5
`define SMSP_SR_MODE_FAULT_FLAG       4
`define SMSP_SR_OUT_DIS    2
`define SMSP_SR_SEL_MGMT   1
`define SMSP_SR_INT_SEL    0

// reset values
`define SMSP_CTRL_RST      8'h00
`define SMSP_STAT_RST      8'h00
`define SMSP_BYTE_RST      8'h00

// byte framing
`define SMSP_LAST_BIT      3'h7
`define SMSP_LAST_TOGGLE   4'hf

// half-period counts of the master serial clock, in cpu cycles
`define SMSP_HALF_DIV4     7'h02
`define SMSP_HALF_DIV8     7'h04
`define SMSP_HALF_DIV16    7'h08
`define SMSP_HALF_DIV32    7'h10
`define SMSP_HALF_DIV64    7'h20
`define SMSP_HALF_DIV128   7'h40

`endif

// ===== smsp_pkg.sv
// types shared by the serial master/slave port.
// assumes smsp_params.svh holds all numeric constants.
package smsp_pkg;

   // master sequencer states
   typedef enum logic {
      SMSP_IDLE,
      SMSP_RUN
   } smsp_mst_state_t;

endpackage : smsp_pkg

// ===== smsp_clkdiv.sv
// master serial clock divider: one tick per half period of the serial clock.
// assumes run_in is held high for the whole of a master transfer.
`include "smsp_params.svh"

module smsp_clkdiv (
   input  wire logic       clk_in,            // cpu clock
   input  wire logic       rst_in,            // sync reset, active high
   input  wire logic       run_in,            // divider runs while high
   input  wire logic       divider_enable_in, // rate code, high bit
   input  wire logic [1:0] rate_select_in,    // rate code, low bits
   output logic            tick_out           // half-period pulse
);

   logic [6:0] cnt_q;
   logic [6:0] last_w;

   // rate code to half-period length; unused codes fall back to the slowest
   function automatic logic [6:0] half_count(input logic [2:0] code);
      case (code)
         3'h4:    half_count = `SMSP_HALF_DIV4;
         3'h0:    half_count = `SMSP_HALF_DIV8;
         3'h1:    half_count = `SMSP_HALF_DIV16;
         3'h6:    half_count = `SMSP_HALF_DIV32;
         3'h2:    half_count = `SMSP_HALF_DIV64;
         3'h3:    half_count = `SMSP_HALF_DIV128;
         default: half_count = `SMSP_HALF_DIV128;
      endcase
   endfunction : half_count

   assign last_w   = half_count({divider_enable_in, rate_select_in}) - 7'h01;
   assign tick_out = run_in && (cnt_q == last_w);

   // counter restarts whenever the master is idle, so the first edge is a full half period
   always_ff @(posedge clk_in) begin
      if (rst_in || !run_in || tick_out) begin
         cnt_q <= 7'h00;
      end else begin
         cnt_q <= cnt_q + 7'h01;
      end
   end

endmodule : smsp_clkdiv

// ===== smsp_props.sv
// checker for the serial port, watching only the top-level pins.
// assumes it is bound into smsp_core and shares its clock and reset.
`include "smsp_params.svh"

module smsp_props (
   input wire logic       clk_in,        // cpu clock
   input wire logic       rst_in,        // sync reset
   input wire logic [7:0] addr_in,       // register address
   input wire logic [7:0] wdata_in,      // write data
   input wire logic       wr_in,         // write strobe
   input wire logic       rd_in,         // read strobe
   input wire logic [7:0] rdata_out,     // read data
   input wire logic       irq_out,       // interrupt
   input wire logic       sck_in,        // clock pin level
   input wire logic       sck_out,       // clock drive value
   input wire logic       sck_oe_n_out,  // clock enable, low drives
   input wire logic       mosi_in,       // mosi pin level
   input wire logic       mosi_out,      // mosi drive value
   input wire logic       mosi_oe_n_out, // mosi enable, low drives
   input wire logic       miso_in,       // miso pin level
   input wire logic       miso_out,      // miso drive value
   input wire logic       miso_oe_n_out, // miso enable, low drives
   input wire logic       ss_n_in        // select pin
);
   logic sm_q; // software select bit, mirrored from writes

   // the select pin only counts while software select is off
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sm_q <= 1'b0;
      end else if (wr_in && addr_in == `SMSP_OFS_STAT) begin
         sm_q <= wdata_in[`SMSP_SR_SEL_MGMT];
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   AST_OE_RESET: assert property ($fell(rst_in) |-> sck_oe_n_out && mosi_oe_n_out && miso_oe_n_out)
      else $error("pins driven right after reset");
   AST_SLAVE_OUT: assert property (!miso_oe_n_out |-> sck_oe_n_out && mosi_oe_n_out)
      else $error("slave data out while clock or mosi driven");
   AST_MASTER_OUT: assert property (!mosi_oe_n_out |-> !sck_oe_n_out && miso_oe_n_out)
      else $error("mosi driven outside master mode");
   AST_SCK_SPACE: assert property (!sck_oe_n_out && !$past(sck_oe_n_out) && $changed(sck_out)
      |=> $stable(sck_out))
      else $error("serial clock half period below two cycles");
   AST_MOSI_SHIFT: assert property (!mosi_oe_n_out && $changed(mosi_out)
      |-> $changed(sck_out) || $past(wr_in))
      else $error("mosi moved without a clock edge or load");
   AST_IRQ_MASK: assert property (wr_in && addr_in == `SMSP_OFS_CTRL
      && !wdata_in[`SMSP_CR_IRQ_EN] |=> !irq_out)
      else $error("interrupt while disabled");
   AST_READ_ONCE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside its cycle");
   AST_RSVD_BIT: assert property ($past(rd_in) && $past(addr_in) == `SMSP_OFS_STAT
      |-> !rdata_out[3])
      else $error("reserved status bit reads one");
   AST_FAULT_DROP: assert property (!sck_oe_n_out && !ss_n_in && !sm_q |=> sck_oe_n_out)
      else $error("master kept driving with select low");
endmodule : smsp_props

bind smsp_core smsp_props u_props (
   .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
   .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n_out(sck_oe_n_out), .mosi_in(mosi_in),
   .mosi_out(mosi_out), .mosi_oe_n_out(mosi_oe_n_out), .miso_in(miso_in),
   .miso_out(miso_out), .miso_oe_n_out(miso_oe_n_out), .ss_n_in(ss_n_in)
);

// ===== smsp_peer.sv
// behavioural slave facing the port, sampled on the cpu clock.
// assumes the serial clock holds each level for two cpu cycles or more.
module smsp_peer (
   input  wire logic       clk_in,       // cpu clock
   input  wire logic       rst_in,       // sync reset
   input  wire logic       clock_phase_in,      // phase, as set in the port
   input  wire logic       load_in,      // restart with a new byte
   input  wire logic [7:0] load_byte_in, // byte sent back
   input  wire logic       sck_in,       // serial clock wire
   input  wire logic       mosi_in,      // data from the port
   output logic            miso_out,     // data to the port
   output logic [7:0]      rx_out        // bits taken from the port
);
   logic [7:0] tx_q;
   logic [4:0] n_q;
   logic       sck_q;
   logic [4:0] n_d;
   logic       edge_w;
   logic       mosi_q;

   assign n_d    = n_q + 5'h01;
   assign edge_w = (sck_in != sck_q) && !load_in;

   // sender; an edge counter avoids trusting the clock's idle level
   always_ff @(posedge clk_in) begin
      if (rst_in || load_in) begin
         tx_q     <= load_byte_in;
         n_q      <= 5'h00;
         sck_q    <= sck_in;
         miso_out <= load_byte_in[7];
      end else if (edge_w) begin
         sck_q <= sck_in;
         n_q   <= n_d;
         // next bit on the non-capture edge, msb first
         if (n_d[0] == clock_phase_in && !n_d[4]) begin
            miso_out <= tx_q[3'h7 - n_d[3:1]];
         end
      end
   end

   // receiver; edges are seen a cycle late, so the data line is taken as it
   // stood when the clock moved, not after the port's own update on that edge
   always_ff @(posedge clk_in) begin
      mosi_q <= mosi_in;
      if (rst_in) begin
         rx_out <= 8'h00;
      // capture on odd edges for phase zero, even for phase one
      end else if (edge_w && n_d[0] != clock_phase_in) begin
         rx_out <= {rx_out[6:0], mosi_q};
      end
   end
endmodule : smsp_peer

// ===== smsp_tb.sv
// self-checking bench: the port as master towards a model slave, plus fault handling.
// assumes design, checker and slave model are compiled before this file.
`include "smsp_params.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ofs_d = `SMSP_OFS_DATA;
   localparam logic [7:0] ofs_c = `SMSP_OFS_CTRL;
   localparam logic [7:0] ofs_s = `SMSP_OFS_STAT;
   logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ss_n = 1'b1, rd_d = 1'b0;
   logic       pload = 1'b0, pcpha = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, pbyte = 8'h00;
   logic [7:0] rdata, prx;
   logic       irq, sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, p_miso;
   logic       sck_w, mosi_w, miso_w;
   logic [7:0] exp_q[$];
   int         miscompares = 0, checks_done = 0, cyc = 0;
   logic [2:0] code [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
   int         half [6] = '{2, 4, 8, 16, 32, 64};

   // a released sck or mosi line shows the inverse of its last drive; a released miso line shows the model slave
   assign sck_w  = sck ^ sck_oe_n;
   assign mosi_w = mosi ^ mosi_oe_n;
   assign miso_w = miso_oe_n ? p_miso : miso;

   smsp_core u_dut (
      .clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .irq_out(irq), .sck_in(sck_w), .sck_out(sck), .sck_oe_n_out(sck_oe_n),
      .mosi_in(mosi_w), .mosi_out(mosi), .mosi_oe_n_out(mosi_oe_n), .miso_in(miso_w),
      .miso_out(miso), .miso_oe_n_out(miso_oe_n), .ss_n_in(ss_n));
   smsp_peer u_peer (
      .clk_in(clk), .rst_in(rst), .clock_phase_in(pcpha), .load_in(pload), .load_byte_in(pbyte),
      .sck_in(sck_w), .mosi_in(mosi_w), .miso_out(p_miso), .rx_out(prx));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic test_done;
      $display("miscompares %0d checks_done %0d", miscompares, checks_done);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      checks_done++;
      if (got !== want) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask : chk

   // one-cycle strobes, changed just after the rising edge
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] want);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(want);
      @(posedge clk);
      rd   <= 1'b0;
   endtask : rd_reg

   // irq and the three enables, looked at mid-cycle once settled
   task automatic pins(input logic [3:0] want);
      @(negedge clk);
      chk({4'h0, irq, sck_oe_n, mosi_oe_n, miso_oe_n}, {4'h0, want});
   endtask : pins

   // one master byte; h is the half period in cycles
   task automatic xfer(input logic [7:0] c, input int h, input bit col);
      logic [7:0] tx;
      logic [7:0] pb;
      int         j;
      tx = 8'($urandom);
      pb = 8'($urandom);
      wr_reg(ofs_c, c & 8'hbf);
      wr_reg(ofs_c, c);
      @(posedge clk);
      pload <= 1'b1;
      pbyte <= pb;
      pcpha <= c[2];
      @(posedge clk);
      pload <= 1'b0;
      rd_reg(ofs_c, c);
      wr_reg(ofs_d, tx);
      if (col) wr_reg(ofs_d, ~tx);
      // reckoned from the last data write, which is the colliding write when col is set
      repeat (14 * h - 2) @(posedge clk);
      pins(4'b0001);
      for (j = 0; j < 4 * h + 8 && irq !== 1'b1; j++) @(negedge clk);
      pins(4'b1001);
      repeat (2 * h + 4) @(posedge clk);
      wr_reg(ofs_d, ~tx);
      rd_reg(ofs_s, col ? 8'hc0 : 8'h80);
      rd_reg(ofs_d, pb);
      rd_reg(ofs_s, 8'h00);
      chk(prx, tx);
   endtask : xfer

   // read data stand one cycle after the strobe; oldest note first
   always @(posedge clk) begin
      rd_d <= rd;
      if (rd_d === 1'b1 && exp_q.size() > 0) begin
         chk(rdata, exp_q.pop_front());
      end
   end

   // hang guard, well above the longest expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         test_done();
      end
   end

   initial begin
      void'($urandom(32'h55f8392e));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_reg(ofs_c, `SMSP_CTRL_RST);
      rd_reg(ofs_s, `SMSP_STAT_RST);
      rd_reg(8'h30, 8'h00);
      rd_reg(ofs_d, `SMSP_BYTE_RST);
      // all six used rate codes against every polarity and phase
      for (int i = 0; i < 6; i++) begin
         for (int m = 0; m < 4; m++) begin
            xfer({2'b11, code[i][2], 1'b1, 2'(m), code[i][1:0]}, half[i], i + m == 0);
         end
      end
      wr_reg(ofs_c, 8'h00);
      // fault from the pin, then from the software select
      for (int i = 0; i < 2; i++) begin
         wr_reg(ofs_s, i ? 8'h03 : 8'h00);
         wr_reg(ofs_c, 8'hf0);
         pins(4'b0001);
         wr_reg(ofs_s, i ? 8'h07 : 8'h04);
         pins(4'b0011);
         @(posedge clk);
         ss_n <= (i != 0);
         if (i) wr_reg(ofs_s, 8'h06);
         repeat (3) @(posedge clk);
         ss_n <= 1'b1;
         if (i) wr_reg(ofs_s, 8'h07);
         pins(4'b1111);
         wr_reg(ofs_c, 8'hf0);
         rd_reg(ofs_c, 8'ha0);
         rd_reg(ofs_s, i ? 8'h17 : 8'h14);
         wr_reg(ofs_c, 8'h70);
         rd_reg(ofs_c, 8'h70);
         rd_reg(ofs_s, i ? 8'h07 : 8'h04);
         pins(4'b0011);
      end
      repeat (4) @(posedge clk);
      test_done();
   end
endmodule : testbench
